// ### test/pmd_dma_cmd_sva.sv
`timescale 1ns/1ns
`default_nettype none
module pmd_dma_cmd_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [31:0] cmd_addr,
  input wire logic [pmd_pkg::LEN_W-1:0] cmd_len,
  input wire logic wr_valid,
  input wire logic [3:0] wr_byte_en_n,
  input wire logic rx_enable,
  input wire logic rx_activity,
  input wire logic frame_done,
  input wire logic crc16_bad,
  input wire logic crc32_bad,
  input wire logic wep_on,
  input wire logic icv_bad,
  input wire logic plcp_start,
  input wire logic frame_checked,
  input wire logic err_crc16,
  input wire logic err_crc32,
  input wire logic err_icv
);
  import pmd_pkg::*;
  logic [7:0] cls_ff;
  logic mwi_en_ff;
  logic [31:0] end_dw;
  logic [31:0] msk;

  // ==========================================================
  // Shadow of line size and enable, so checks track reprogramming
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cls_ff <= RST_CLS_REG;
      mwi_en_ff <= RST_CMD_REG[CMD_MWI_BIT];
    end else if (cfg_wr_en && cfg_addr == OFS_CLS_REG) begin
      cls_ff <= cfg_wdata[7:0];
    end else if (cfg_wr_en && cfg_addr == OFS_CMD_REG) begin
      mwi_en_ff <= cfg_wdata[CMD_MWI_BIT];
    end
  end

  // Dword just past the burst, and the line mask
  assign end_dw = 32'(cmd_addr[31:2]) + 32'(cmd_len);
  assign msk = 32'(cls_ff - 8'h01);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // Frame report steps
  sequence s_report;
    ##1 frame_checked;
  endsequence

  a_plcp_start_on: assert property (
    $rose(rx_activity) && rx_enable |=> plcp_start)
    else $error("preamble start missing");
  a_crc_report: assert property (
    frame_done |-> s_report ##0
    (err_crc16 == $past(crc16_bad) && err_crc32 == $past(crc32_bad)))
    else $error("crc flags wrong");
  a_icv_report: assert property (
    frame_done |-> s_report ##0
    err_icv == ($past(wep_on) && $past(icv_bad)))
    else $error("icv flag wrong");
  a_mrl_reaches_line: assert property (
    cmd_valid && cmd_code == BUS_MRL |-> (end_dw & msk) == 32'h0)
    else $error("read line misses boundary");
  // Size zero has no boundary at all, so it is left out here
  a_mr_stops_short: assert property (
    cmd_valid && cmd_code == BUS_MR && cls_ff != 8'h00
    && (cls_ff & (cls_ff - 8'h01)) == 8'h00 |-> (end_dw & msk) != 32'h0)
    else $error("plain read reaches boundary");
  a_mrm_whole_lines: assert property (
    cmd_valid && cmd_code == BUS_MRM
    |-> ((32'(cmd_addr[31:2]) | 32'(cmd_len)) & msk) == 32'h0)
    else $error("read multiple not whole lines");
  a_mwi_byte_en: assert property (wr_valid |-> wr_byte_en_n == BE_ALL_N)
    else $error("byte enables not all active");
  a_mwi_line_size: assert property (
    cmd_valid && cmd_code == BUS_MWI
    |-> cmd_len inside {16'h8, 16'h10} && cmd_len == 16'(cls_ff))
    else $error("invalidate with bad line size");
  a_mwi_aligned: assert property (
    cmd_valid && cmd_code == BUS_MWI
    |-> (32'(cmd_addr[31:2]) & msk) == 32'h0)
    else $error("invalidate not line aligned");
  a_mwi_enabled: assert property (
    cmd_valid && cmd_code == BUS_MWI |-> mwi_en_ff)
    else $error("invalidate while disabled");
endmodule

bind pmd_dma_cmd pmd_dma_cmd_sva chk_u (.sys_clk, .rst, .cfg_wr_en, .cfg_addr,
  .cfg_wdata, .cmd_valid, .cmd_code, .cmd_addr, .cmd_len, .wr_valid,
  .wr_byte_en_n, .rx_enable, .rx_activity, .frame_done, .crc16_bad,
  .crc32_bad, .wep_on, .icv_bad, .plcp_start, .frame_checked, .err_crc16,
  .err_crc32, .err_icv);
`default_nettype wire

// ### test/pmd_dma_cmd_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pmd_dma_cmd_tb;
  import pmd_pkg::*;
  logic sys_clk, rst, cfg_wr_en, cfg_rd_en, tx_req_valid, tx_req_ready;
  logic tx_fifo_almost_full, rx_addr_load, rx_flush, rx_in_valid, rx_in_ready;
  logic cmd_valid, cmd_ready, wr_valid, wr_ready, wr_last, rx_enable, hold;
  logic rx_activity, rx_short_mode, frame_done, crc16_bad, crc32_bad, wep_on;
  logic icv_bad, plcp_start, plcp_short, frame_checked;
  logic err_crc16, err_crc32, err_icv;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, tx_req_addr, rx_addr, cmd_addr;
  logic [LEN_W-1:0] tx_req_len, cmd_len;
  logic [DATA_W-1:0] rx_in_data, wr_data;
  logic [3:0] cmd_code, wr_byte_en_n;
  int num_errors, compares, nwr, nlast, npush;

  pmd_dma_cmd dut_u (.sys_clk, .rst, .cfg_wr_en, .cfg_rd_en, .cfg_addr,
    .cfg_wdata, .cfg_rdata, .tx_req_valid, .tx_req_ready, .tx_req_addr,
    .tx_req_len, .tx_fifo_almost_full, .rx_addr_load, .rx_addr, .rx_flush,
    .rx_in_valid, .rx_in_ready, .rx_in_data, .cmd_valid, .cmd_ready,
    .cmd_code, .cmd_addr, .cmd_len, .wr_valid, .wr_ready, .wr_data,
    .wr_byte_en_n, .wr_last, .rx_enable, .rx_activity, .rx_short_mode,
    .frame_done, .crc16_bad, .crc32_bad, .wep_on, .icv_bad, .plcp_start,
    .plcp_short, .frame_checked, .err_crc16, .err_crc32, .err_icv);
  pmd_host_model host_u (.sys_clk, .rst, .hold, .cmd_valid, .wr_valid,
    .cmd_ready, .wr_ready);

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Data phases must carry the pushed words in order
  always @(posedge sys_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      chk(wr_data, 32'(nwr));
      nwr = nwr + 1;
      if (wr_last === 1'b1) nlast = nwr;
    end
  end

  // ==========================================================
  // Common tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic bound(input int i);
    if (i >= 300) begin
      num_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
    end
  endtask
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr_en = 1'b1;
    tick();
    cfg_wr_en = 1'b0;
    tick();
  endtask
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    cfg_addr = a;
    cfg_rd_en = 1'b1;
    tick();
    cfg_rd_en = 1'b0;
    d = cfg_rdata;
    tick();
  endtask
  task automatic exp_cmd(input logic [3:0] c, input logic [31:0] a,
      input int n);
    int i;
    // Judge while the command stands, then pass its accepting edge
    for (i = 0; i < 300 && cmd_valid !== 1'b1; i++) tick();
    bound(i);
    chk(cmd_code, c);
    chk(cmd_addr, a);
    chk(cmd_len, n);
    for (i = 0; i < 300 && cmd_valid === 1'b1; i++) tick();
    bound(i);
  endtask
  task automatic tx_go(input logic [31:0] a, input logic [15:0] n);
    int i;
    tx_req_addr = a;
    tx_req_len = n;
    tx_req_valid = 1'b1;
    for (i = 0; i < 300 && tx_req_ready !== 1'b1; i++) tick();
    bound(i);
    tick();
    tx_req_valid = 1'b0;
  endtask
  task automatic push(input int n);
    int i, j;
    for (j = 0; j < n; j++) begin
      rx_in_valid = 1'b1;
      rx_in_data = 32'(npush);
      for (i = 0; i < 300 && rx_in_ready !== 1'b1; i++) tick();
      bound(i);
      tick();
      npush++;
    end
    rx_in_valid = 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    cfg_rd(OFS_CLS_REG, d);
    chk(d, 32'(RST_CLS_REG));
    cfg_rd(OFS_CMD_REG, d);
    chk(d, 32'(RST_CMD_REG));
    cfg_wr(OFS_CMD_REG, 32'h10);
    cfg_rd(OFS_CMD_REG, d);
    chk(d, 32'h10);
    cfg_wr(8'h3c, 32'hffff_ffff);
    cfg_rd(8'h3c, d);
    chk(d, 32'h0);
    $display("register test done");
  endtask
  task automatic t_tx;
    cfg_wr(OFS_CLS_REG, 32'(CLS_16));
    tx_go(32'h44, 16'd20);
    exp_cmd(BUS_MRL, 32'h44, 15);
    exp_cmd(BUS_MR, 32'h80, 5);
    tx_go(32'h40, 16'd40);
    exp_cmd(BUS_MRM, 32'h40, 32);
    exp_cmd(BUS_MR, 32'hc0, 8);
    tx_fifo_almost_full = 1'b1;
    tx_go(32'h100, 16'd40);
    exp_cmd(BUS_MRM, 32'h100, 16);
    exp_cmd(BUS_MRM, 32'h140, 16);
    exp_cmd(BUS_MR, 32'h180, 8);
    tx_fifo_almost_full = 1'b0;
    cfg_wr(OFS_CLS_REG, 32'(CLS_8));
    tx_go(32'h104, 16'd7);
    exp_cmd(BUS_MRL, 32'h104, 7);
    $display("transmit split test done");
  endtask
  task automatic rx_case(input logic [7:0] cls, input logic [31:0] cmdr,
      input logic [31:0] a, input int n, input logic [3:0] code,
      input logic stall);
    int i;
    cfg_wr(OFS_CLS_REG, 32'(cls));
    cfg_wr(OFS_CMD_REG, cmdr);
    rx_addr = a;
    rx_addr_load = 1'b1;
    tick();
    rx_addr_load = 1'b0;
    hold = stall;
    push(n);
    if (stall) begin
      tick();
      chk(rx_in_ready, 1'b0);
      hold = 1'b0;
    end
    rx_flush = 1'b1;
    exp_cmd(code, a, code == BUS_MWI ? int'(cls) : n);
    rx_flush = 1'b0;
    for (i = 0; i < 300 && nwr < npush; i++) tick();
    bound(i);
    chk(nlast, npush);
    $display("receive test at %h done", a);
  endtask
  task automatic t_frame;
    int k;
    // Activity with receive off must not start a header pass
    rx_activity = 1'b1;
    tick();
    chk(plcp_start, 1'b0);
    rx_activity = 1'b0;
    tick();
    rx_enable = 1'b1;
    rx_short_mode = 1'b1;
    rx_activity = 1'b1;
    tick();
    chk({plcp_start, plcp_short}, 2'b11);
    rx_activity = 1'b0;
    for (k = 0; k < 16; k++) begin
      {wep_on, icv_bad, crc32_bad, crc16_bad} = 4'(k);
      frame_done = 1'b1;
      tick();
      frame_done = 1'b0;
      chk(frame_checked, 1'b1);
      chk({err_icv, err_crc32, err_crc16}, {k[3] & k[2], k[1:0]});
      tick();
      chk(frame_checked, 1'b0);
    end
    $display("frame check test done");
  endtask

  initial begin
    {cfg_wr_en, cfg_rd_en, tx_req_valid, tx_fifo_almost_full, rx_addr_load,
      rx_flush, rx_in_valid, rx_enable, rx_activity, rx_short_mode, hold,
      frame_done, crc16_bad, crc32_bad, wep_on, icv_bad, cfg_addr, cfg_wdata,
      tx_req_addr, tx_req_len, rx_addr, rx_in_data} = '0;
    rst = 1'b1;
    repeat (6) tick();
    rst = 1'b0;
    tick();
    t_regs();
    t_tx();
    rx_case(CLS_16, 32'h10, 32'h200, 16, BUS_MWI, 1'b1);
    rx_case(CLS_8, 32'h10, 32'h300, 8, BUS_MWI, 1'b0);
    // Two lines queued behind a held command: the burst must extend
    rx_case(CLS_8, 32'h10, 32'h800, 16, BUS_MWI, 1'b1);
    rx_case(CLS_8, 32'h0, 32'h400, 8, BUS_MW, 1'b0);
    rx_case(CLS_8, 32'h10, 32'h504, 7, BUS_MW, 1'b0);
    rx_case(8'h04, 32'h10, 32'h600, 4, BUS_MW, 1'b0);
    rx_case(CLS_8, 32'h10, 32'h700, 3, BUS_MW, 1'b0);
    t_frame();
    end_sim();
  end
endmodule
`default_nettype wire

// ### test/pmd_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pmd_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic cmd_valid,
  input wire logic wr_valid,
  output logic cmd_ready,
  output logic wr_ready
);
  logic [1:0] ph_ff;

  // Phase counter, gives a wait state every third clock cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ph_ff <= 2'h0;
    end else begin
      ph_ff <= (ph_ff == 2'h2) ? 2'h0 : ph_ff + 2'h1;
    end
  end

  // No prefetch store here, so nothing stale can pass a sync event
  assign cmd_ready = cmd_valid && !hold;
  // Accepts data on two of every three cycles; hold does not stall it
  assign wr_ready = wr_valid && ph_ff != 2'h0;
endmodule
`default_nettype wire

// ### verilog/pmd_dma_cmd.sv
`timescale 1ns/1ns
`default_nettype none
module pmd_dma_cmd (
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration space access
  input wire logic cfg_wr_en,
  input wire logic cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  // Transmit read requests
  input wire logic tx_req_valid,
  output logic tx_req_ready,
  input wire logic [31:0] tx_req_addr,
  input wire logic [pmd_pkg::LEN_W-1:0] tx_req_len,
  input wire logic tx_fifo_almost_full,
  // Receive data and buffer address
  input wire logic rx_addr_load,
  input wire logic [31:0] rx_addr,
  input wire logic rx_flush,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  input wire logic [pmd_pkg::DATA_W-1:0] rx_in_data,
  // Bus command out
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [3:0] cmd_code,
  output logic [31:0] cmd_addr,
  output logic [pmd_pkg::LEN_W-1:0] cmd_len,
  // Write data phases
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [pmd_pkg::DATA_W-1:0] wr_data,
  output logic [3:0] wr_byte_en_n,
  output logic wr_last,
  // Receive frame checks
  input wire logic rx_enable,
  input wire logic rx_activity,
  input wire logic rx_short_mode,
  input wire logic frame_done,
  input wire logic crc16_bad,
  input wire logic crc32_bad,
  input wire logic wep_on,
  input wire logic icv_bad,
  output logic plcp_start,
  output logic plcp_short,
  output logic frame_checked,
  output logic err_crc16,
  output logic err_crc32,
  output logic err_icv
);
  import pmd_pkg::*;

  pmd_fifo_if #(.W(DATA_W), .CW(CNT_W)) rxf ();

  pmd_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH), .CW(CNT_W)) u_rx_fifo (
    .clk(sys_clk),
    .rst(rst),
    .f(rxf.store)
  );

  // ==========================================================
  // Configuration registers
  logic [7:0] cls_ff;
  logic [15:0] cmdreg_ff;
  logic [31:0] cfg_rdata_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cls_ff <= RST_CLS_REG;
      cmdreg_ff <= RST_CMD_REG;
    end else if (cfg_wr_en) begin
      if (cfg_addr == OFS_CLS_REG) begin
        cls_ff <= cfg_wdata[7:0];
      end
      if (cfg_addr == OFS_CMD_REG) begin
        cmdreg_ff <= cfg_wdata[15:0];
      end
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_ff <= '0;
    end else if (cfg_rd_en) begin
      unique case (cfg_addr)
        OFS_CLS_REG: cfg_rdata_ff <= {24'h000000, cls_ff};
        OFS_CMD_REG: cfg_rdata_ff <= {16'h0000, cmdreg_ff};
        default: cfg_rdata_ff <= '0;
      endcase
    end
  end
  assign cfg_rdata = cfg_rdata_ff;

  // ==========================================================
  // Line geometry from the live line size register
  logic line_ok;
  logic mwi_cls_ok;
  logic [7:0] cls_mask;
  logic [29:0] tx_waddr_ff;
  logic [29:0] rx_waddr_ff;
  logic [7:0] tx_off;
  logic [7:0] rx_off;
  logic [8:0] tx_dist;
  logic [8:0] rx_dist;

  // Non power of two sizes have no usable boundary: plain commands
  assign cls_mask = cls_ff - 8'h01;
  assign line_ok = (cls_ff != 8'h00) && ((cls_ff & cls_mask) == 8'h00);
  assign mwi_cls_ok = (cls_ff == CLS_8) || (cls_ff == CLS_16);
  assign tx_off = tx_waddr_ff[7:0] & cls_mask;
  assign rx_off = rx_waddr_ff[7:0] & cls_mask;
  assign tx_dist = {1'b0, cls_ff} - {1'b0, tx_off};
  assign rx_dist = {1'b0, cls_ff} - {1'b0, rx_off};

  // ==========================================================
  // Transmit read command choice
  logic [LEN_W-1:0] tx_left_ff;
  logic [3:0] tx_code;
  logic [LEN_W-1:0] tx_len;
  logic [LEN_W-1:0] cls_len;
  logic [LEN_W-1:0] tx_dist_len;

  assign cls_len = {{(LEN_W-8){1'b0}}, cls_ff};
  assign tx_dist_len = {{(LEN_W-9){1'b0}}, tx_dist};

  always_comb begin
    tx_code = BUS_MR;
    tx_len = tx_left_ff;
    if (line_ok) begin
      if (tx_off != 8'h00) begin
        if (tx_left_ff >= tx_dist_len) begin
          tx_code = BUS_MRL;
          tx_len = tx_dist_len;
        end
      end else if (tx_left_ff >= cls_len) begin
        tx_code = BUS_MRM;
        if (tx_fifo_almost_full) begin
          tx_len = cls_len;
        end else begin
          tx_len = tx_left_ff & ~(cls_len - 1'b1);
        end
      end
    end
    // Otherwise the tail ends short of a boundary: plain read
  end

  // ==========================================================
  // Receive write command choice
  logic mwi_ok;
  logic [CNT_W-1:0] cnt;
  logic [8:0] cnt9;
  logic [8:0] mw_len;
  logic rx_go;

  assign cnt = rxf.count;
  assign cnt9 = {{(9-CNT_W){1'b0}}, cnt};
  assign mwi_ok = mwi_cls_ok && (rx_off == 8'h00)
    && (cnt9 >= {1'b0, cls_ff})
    && cmdreg_ff[CMD_MWI_BIT];

  // Plain write stops at the boundary so the next burst starts aligned
  always_comb begin
    mw_len = cnt9;
    if (line_ok && (rx_dist < cnt9)) begin
      mw_len = rx_dist;
    end
  end

  // Wait for a boundary worth of data unless the frame tail is flushed
  assign rx_go = mwi_ok || ((cnt != '0)
    && (rx_flush || (line_ok && (cnt9 >= rx_dist))));

  // ==========================================================
  // Sequencer
  pmd_state_t st_ff;
  logic cmd_valid_ff;
  logic [3:0] cmd_code_ff;
  logic [31:0] cmd_addr_ff;
  logic [LEN_W-1:0] cmd_len_ff;
  logic tx_req_ready_ff;
  logic mwi_run_ff;
  logic [8:0] wr_left_ff;
  logic wr_valid_ff;
  logic [DATA_W-1:0] wr_data_ff;
  logic wr_last_ff;
  logic pop;
  logic extend;
  logic tx_take;

  assign tx_take = tx_req_valid && tx_req_ready_ff;
  assign pop = (st_ff == ST_RX_DATA) && (!wr_valid_ff || wr_ready)
    && (wr_left_ff != 9'h000) && rxf.out_valid;
  // At the line end, go on only for a complete following line
  assign extend = mwi_run_ff && (wr_left_ff == 9'h001)
    && mwi_cls_ok && cmdreg_ff[CMD_MWI_BIT]
    && (cnt9 > {1'b0, cls_ff});

  assign rxf.in_valid = rx_in_valid;
  assign rxf.in_data = rx_in_data;
  assign rxf.out_ready = pop;
  assign rx_in_ready = rxf.in_ready;

  // Receive side gets priority: its FIFO is only 16 words deep
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_IDLE;
      cmd_valid_ff <= 1'b0;
      cmd_code_ff <= BUS_MR;
      cmd_addr_ff <= '0;
      cmd_len_ff <= '0;
      mwi_run_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        ST_IDLE: begin
          if (rx_go) begin
            cmd_valid_ff <= 1'b1;
            cmd_code_ff <= mwi_ok ? BUS_MWI : BUS_MW;
            cmd_addr_ff <= {rx_waddr_ff, BURST_LINEAR};
            cmd_len_ff <= mwi_ok ? cls_len : {{(LEN_W-9){1'b0}}, mw_len};
            mwi_run_ff <= mwi_ok;
            st_ff <= ST_RX_CMD;
          end else if (tx_left_ff != '0) begin
            cmd_valid_ff <= 1'b1;
            cmd_code_ff <= tx_code;
            cmd_addr_ff <= {tx_waddr_ff, BURST_LINEAR};
            cmd_len_ff <= tx_len;
            st_ff <= ST_TX_CMD;
          end
        end
        ST_TX_CMD: begin
          if (cmd_ready) begin
            cmd_valid_ff <= 1'b0;
            st_ff <= ST_IDLE;
          end
        end
        ST_RX_CMD: begin
          if (cmd_ready) begin
            cmd_valid_ff <= 1'b0;
            st_ff <= ST_RX_DATA;
          end
        end
        ST_RX_DATA: begin
          if (wr_valid_ff && wr_ready && wr_last_ff) begin
            mwi_run_ff <= 1'b0;
            st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Transmit address and remaining length
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_waddr_ff <= '0;
      tx_left_ff <= '0;
      tx_req_ready_ff <= 1'b0;
    end else begin
      if (tx_take) begin
        tx_waddr_ff <= tx_req_addr[31:2];
        tx_left_ff <= tx_req_len;
        tx_req_ready_ff <= 1'b0;
      end else if (st_ff == ST_TX_CMD && cmd_ready) begin
        tx_waddr_ff <= tx_waddr_ff + {{(30-LEN_W){1'b0}}, cmd_len_ff};
        tx_left_ff <= tx_left_ff - cmd_len_ff;
      end else begin
        tx_req_ready_ff <= (tx_left_ff == '0) && (st_ff != ST_TX_CMD);
      end
    end
  end

  // Receive write address and data phases
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_waddr_ff <= '0;
      wr_left_ff <= '0;
      wr_valid_ff <= 1'b0;
      wr_data_ff <= '0;
      wr_last_ff <= 1'b0;
    end else begin
      if (rx_addr_load && st_ff == ST_IDLE) begin
        rx_waddr_ff <= rx_addr[31:2];
      end else if (pop) begin
        rx_waddr_ff <= rx_waddr_ff + 30'h00000001;
      end
      if (st_ff == ST_RX_CMD && cmd_ready) begin
        wr_left_ff <= cmd_len_ff[8:0];
      end else if (pop) begin
        wr_left_ff <= extend ? {1'b0, cls_ff} : wr_left_ff - 9'h001;
      end
      if (pop) begin
        wr_valid_ff <= 1'b1;
        wr_data_ff <= rxf.out_data;
        wr_last_ff <= (wr_left_ff == 9'h001) && !extend;
      end else if (wr_ready) begin
        wr_valid_ff <= 1'b0;
        wr_last_ff <= 1'b0;
      end
    end
  end

  assign cmd_valid = cmd_valid_ff;
  assign cmd_code = cmd_code_ff;
  assign cmd_addr = cmd_addr_ff;
  assign cmd_len = cmd_len_ff;
  assign tx_req_ready = tx_req_ready_ff;
  assign wr_valid = wr_valid_ff;
  assign wr_data = wr_data_ff;
  assign wr_last = wr_last_ff;
  assign wr_byte_en_n = BE_ALL_N;

  // ==========================================================
  // Receive frame start and integrity reporting
  logic act_d_ff;
  logic plcp_start_ff;
  logic plcp_short_ff;
  logic frame_checked_ff;
  logic err_crc16_ff;
  logic err_crc32_ff;
  logic err_icv_ff;

  // Rising activity only, so one frame starts one header pass
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_d_ff <= 1'b0;
      plcp_start_ff <= 1'b0;
      plcp_short_ff <= 1'b0;
    end else begin
      act_d_ff <= rx_activity;
      plcp_start_ff <= rx_enable && rx_activity && !act_d_ff;
      if (rx_enable && rx_activity && !act_d_ff) begin
        plcp_short_ff <= rx_short_mode;
      end
    end
  end

  // Results hold until the next frame completes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_checked_ff <= 1'b0;
      err_crc16_ff <= 1'b0;
      err_crc32_ff <= 1'b0;
      err_icv_ff <= 1'b0;
    end else begin
      frame_checked_ff <= frame_done;
      if (frame_done) begin
        err_crc16_ff <= crc16_bad;
        err_crc32_ff <= crc32_bad;
        err_icv_ff <= wep_on && icv_bad;
      end
    end
  end

  assign plcp_start = plcp_start_ff;
  assign plcp_short = plcp_short_ff;
  assign frame_checked = frame_checked_ff;
  assign err_crc16 = err_crc16_ff;
  assign err_crc32 = err_crc32_ff;
  assign err_icv = err_icv_ff;
endmodule
`default_nettype wire

// ### verilog/pmd_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module pmd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic rst,
  pmd_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic in_ready_ff;
  logic push;
  logic pop;

  // ==========================================================
  // Handshakes; ready is a flop so the top sees a clean level
  assign push = f.in_valid && in_ready_ff;
  assign pop = f.out_ready && (cnt_ff != '0);
  assign f.in_ready = in_ready_ff;
  assign f.out_valid = (cnt_ff != '0);
  assign f.out_data = mem_ff[rd_ptr_ff];
  assign f.count = cnt_ff;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // Storage written only, never reset: contents are don't care
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= f.in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      in_ready_ff <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      cnt_ff <= nxt_cnt;
      in_ready_ff <= (nxt_cnt != FULL_CNT);
    end
  end
endmodule
`default_nettype wire

// ### verilog/pmd_fifo_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pmd_fifo_if #(
  parameter int W = 32,
  parameter int CW = 5
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  logic [CW-1:0] count;

  modport store (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data, count
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data, count
  );
endinterface
`default_nettype wire

// ### verilog/pmd_pkg.sv
`default_nettype none
package pmd_pkg;
  // ==========================================================
  // Configuration space map
  localparam logic [7:0] OFS_CMD_REG = 8'h04;
  localparam logic [7:0] OFS_CLS_REG = 8'h0c;
  localparam int CMD_MWI_BIT = 4;
  localparam logic [15:0] RST_CMD_REG = 16'h0000;
  localparam logic [7:0] RST_CLS_REG = 8'h00;
  localparam logic [7:0] CLS_8 = 8'h08;
  localparam logic [7:0] CLS_16 = 8'h10;

  // ==========================================================
  // Bus commands
  localparam logic [3:0] BUS_MR = 4'h6;
  localparam logic [3:0] BUS_MRL = 4'he;
  localparam logic [3:0] BUS_MRM = 4'hc;
  localparam logic [3:0] BUS_MW = 4'h7;
  localparam logic [3:0] BUS_MWI = 4'hf;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [1:0] BURST_LINEAR = 2'h0;

  // ==========================================================
  // Sizes
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int LEN_W = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX_CMD = 2'b01,
    ST_RX_CMD = 2'b10,
    ST_RX_DATA = 2'b11
  } pmd_state_t;
endpackage
`default_nettype wire
